// *** pkg/pwr_mode_pkg.sv ***
// Shared constants for the power-mode controller and its register slave.
package pwr_mode_pkg;
  // Printed register index and its byte address on the bus.
  localparam logic [11:0] POWER_CONTROL_IDX = 12'h087;
  localparam logic [11:0] POWER_CONTROL_ADDR = 12'h21C;
  // Additional registers of this block.
  localparam logic [11:0] WAKE_ENABLE_IDX = 12'h088;
  localparam logic [11:0] WAKE_ENABLE_ADDR = 12'h220;
  localparam logic [11:0] POWER_STATUS_IDX = 12'h089;
  localparam logic [11:0] POWER_STATUS_ADDR = 12'h224;
  // Field positions inside power_control_reg.
  localparam int IDLE_BIT_POS = 0;
  localparam int POWER_DOWN_BIT_POS = 1;
  localparam int GENERAL_FLAG_ZERO_POS = 2;
  localparam int GENERAL_FLAG_ONE_POS = 3;
  localparam int POWER_ON_FLAG_POS = 4;
  localparam int SERIAL_FRAME_ERROR_SELECT_POS = 6;
  localparam int SERIAL_RATE_DOUBLE_POS = 7;
  // Writable bits of power_control_reg; bit 5 is reserved.
  localparam logic [7:0] POWER_CONTROL_WMASK = 8'hDF;
  // Reset values.
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h10;
  localparam logic [5:0] WAKE_ENABLE_RESET = 6'h3F;
  // Interrupt source positions in the pending vector.
  localparam int SRC_EXT_A = 0;
  localparam int SRC_EXT_B = 1;
  localparam int SRC_PIN_CHANGE = 2;
  localparam int SRC_WATCHDOG = 3;
  localparam int SRC_WAKEUP_TIMER = 4;
  localparam int SRC_BROWNOUT = 5;
  localparam int PD_WAKE_SOURCES = 6;
  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Operating modes of the controller.
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PD_STOP,
    MODE_PD_SETTLE
  } pwr_mode_t;
endpackage

// *** rtl/axil_reg_slave.sv ***
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/10ps
module axil_reg_slave #(
  parameter int AW = 12
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Write address and data channels.
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side.
  output logic reg_wr,
  output logic [AW-1:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_wok,
  output logic [AW-1:0] reg_raddr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rok
);
  logic aw_held;
  logic w_held;

  // Address and data are taken in either order and held until both are in.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign reg_wr = aw_held && w_held && !s_axi_bvalid;
  assign reg_raddr = s_axi_araddr;
  assign s_axi_arready = !s_axi_rvalid;

  // Capture the write address.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      reg_waddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      reg_waddr <= s_axi_awaddr;
    end else if (reg_wr) begin
      aw_held <= 1'b0;
    end
  end

  // Capture the write data and lanes.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      reg_wdata <= '0;
      reg_wstrb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      reg_wdata <= s_axi_wdata;
      reg_wstrb <= s_axi_wstrb;
    end else if (reg_wr) begin
      w_held <= 1'b0;
    end
  end

  // The response follows the register strobe by one edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pwr_mode_pkg::RESP_OKAY;
    end else if (reg_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_wok ? pwr_mode_pkg::RESP_OKAY
                             : pwr_mode_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data is sampled at the address handshake, so it never tears.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pwr_mode_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= reg_rok ? reg_rdata : 32'h0000_0000;
      s_axi_rresp <= reg_rok ? pwr_mode_pkg::RESP_OKAY
                             : pwr_mode_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** rtl/cpu_power_mode_control.sv ***
// Power-mode controller: idle and power-down entry, wake-up and resume.
//
// Behaviour
// R1: Power-down bit set stops CPU and peripheral clocks and holds the PC.
// R2: Idle bit set stops only the CPU clock; peripherals keep running.
// R3: Power-down wake clears the bit, services the interrupt, then resumes.
// R4: Idle wake clears the bit, services the interrupt, resumes after return.
// R5: Both bits written together enter power-down only, never idle after.
// R6: In idle nothing is fetched; CPU registers and port outputs stay frozen.
// R7: The write that sets idle is the last completed access before stopping.
// R8: The write that sets power-down is the last before the clock stops.
// R9: Any enabled interrupt ends idle.
// R10: Any reset other than software reset ends idle; the code ignores a brown-out reset while the detector is disabled.
// R11: Software must let the watchdog run in idle to wake by its reset.
// R12: In power-down flash stops, RAM retains and port pins hold values.
// R13: Non-software resets end power-down; brown-out only if detector enabled.
// R14: Pin or power-on reset restarts the CPU from the reset vector.
// R15: External interrupt restarts the oscillator; service waits until stable.
// R16: Only the six listed sources can wake from power-down.
// R17: Software should prefer low-power brown-out detection in power-down.
// R18: A qualifying reset clears both idle and power-down bits.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
module cpu_power_mode_control #(
  parameter int AW = 12,
  parameter int IRQ_SOURCES = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite write channels.
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt logic: enabled and pending sources, one bit each.
  input wire logic [IRQ_SOURCES-1:0] irq_pending,
  // Reset sources, each a one-cycle pulse, and the brown-out detector enable level.
  input wire logic reset_power_on,
  input wire logic reset_pin,
  input wire logic reset_brownout,
  input wire logic reset_watchdog,
  input wire logic reset_software,
  input wire logic brownout_detect_enabled,
  // Clock system.
  input wire logic osc_stable,
  output logic osc_run,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  // CPU core.
  output logic cpu_hold,
  output logic cpu_restart,
  output logic wake_service,
  // Memories and ports.
  output logic flash_stop,
  output logic ram_retain,
  output logic port_hold,
  // Serial options kept in the control register.
  output logic serial_rate_double,
  output logic serial_frame_error_select
);
  pwr_mode_pkg::pwr_mode_t mode;
  logic [7:0] power_control_reg;
  logic [5:0] wake_enable;
  logic [5:0] last_wake;
  logic reg_wr;
  logic [AW-1:0] reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0] reg_wstrb;
  logic reg_wok;
  logic [AW-1:0] reg_raddr;
  logic [31:0] reg_rdata;
  logic reg_rok;
  logic qualifying_reset;
  logic wr_control;
  logic wr_wake_enable;
  logic [5:0] pd_wake;
  logic idle_wake;

  // Decodes one of this block's word addresses.
  function automatic logic addr_hit(input logic [AW-1:0] a,
                                    input logic [11:0] target);
    addr_hit = (a == target[AW-1:0]);
  endfunction

  // True when an address names any register of this block.
  function automatic logic addr_mapped(input logic [AW-1:0] a);
    addr_mapped = addr_hit(a, pwr_mode_pkg::POWER_CONTROL_ADDR)
               || addr_hit(a, pwr_mode_pkg::WAKE_ENABLE_ADDR)
               || addr_hit(a, pwr_mode_pkg::POWER_STATUS_ADDR);
  endfunction

  // Bus slave; registers live here, the slave only moves transfers.
  axil_reg_slave #(.AW(AW)) u_slave (
    .clk_sys(clk_sys),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_wok(reg_wok),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_rok(reg_rok)
  );

  // Address decode; only byte lane 0 carries register data.
  assign reg_wok = addr_mapped(reg_waddr);
  assign reg_rok = addr_mapped(reg_raddr);
  assign wr_control = reg_wr && reg_wstrb[0]
    && addr_hit(reg_waddr, pwr_mode_pkg::POWER_CONTROL_ADDR);
  assign wr_wake_enable = reg_wr && reg_wstrb[0]
    && addr_hit(reg_waddr, pwr_mode_pkg::WAKE_ENABLE_ADDR);

  // A brown-out reset only counts when the detector was armed.
  assign qualifying_reset = reset_power_on || reset_pin
    || reset_watchdog // R11
    || (reset_brownout && brownout_detect_enabled); // R13

  // Only the six listed sources, each gated by its enable, leave power-down.
  assign pd_wake = irq_pending[pwr_mode_pkg::PD_WAKE_SOURCES-1:0]
    & wake_enable; // R16
  // Peripherals still run in idle, so any enabled interrupt is a wake.
  assign idle_wake = |irq_pending; // R9

  // Mode sequencer. Qualifying resets win over every other event.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode <= pwr_mode_pkg::MODE_RUN;
    end else if (qualifying_reset) begin
      mode <= pwr_mode_pkg::MODE_RUN; // R10 R13
    end else begin
      unique case (mode)
        pwr_mode_pkg::MODE_RUN: begin
          // Power-down is tested first so a combined write never idles.
          if (wr_control
              && reg_wdata[pwr_mode_pkg::POWER_DOWN_BIT_POS]) begin
            mode <= pwr_mode_pkg::MODE_PD_STOP; // R5 R8
          end else if (wr_control
              && reg_wdata[pwr_mode_pkg::IDLE_BIT_POS]) begin
            mode <= pwr_mode_pkg::MODE_IDLE; // R7
          end
        end
        pwr_mode_pkg::MODE_IDLE: begin
          if (idle_wake) begin
            mode <= pwr_mode_pkg::MODE_RUN; // R4
          end
        end
        pwr_mode_pkg::MODE_PD_STOP: begin
          if (|pd_wake) begin
            mode <= pwr_mode_pkg::MODE_PD_SETTLE; // R15
          end
        end
        pwr_mode_pkg::MODE_PD_SETTLE: begin
          // The service routine must not run on an unsettled oscillator.
          if (osc_stable) begin
            mode <= pwr_mode_pkg::MODE_RUN; // R15
          end
        end
      endcase
    end
  end

  // Control register: software fields, hardware-cleared mode bits.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_control_reg <= pwr_mode_pkg::POWER_CONTROL_RESET;
    end else begin
      if (wr_control) begin
        power_control_reg <= reg_wdata[7:0]
          & pwr_mode_pkg::POWER_CONTROL_WMASK;
      end
      if (qualifying_reset) begin
        power_control_reg[pwr_mode_pkg::IDLE_BIT_POS] <= 1'b0; // R18
        power_control_reg[pwr_mode_pkg::POWER_DOWN_BIT_POS] <= 1'b0; // R18
      end else if (mode == pwr_mode_pkg::MODE_IDLE && idle_wake) begin
        power_control_reg[pwr_mode_pkg::IDLE_BIT_POS] <= 1'b0; // R4
      end else if (mode == pwr_mode_pkg::MODE_PD_STOP && |pd_wake) begin
        // Idle is dropped too, so leaving power-down never lands in idle.
        power_control_reg[pwr_mode_pkg::IDLE_BIT_POS] <= 1'b0; // R5
        power_control_reg[pwr_mode_pkg::POWER_DOWN_BIT_POS] <= 1'b0; // R3
      end
      // Power-on sets its flag; the set wins over a software clear.
      if (reset_power_on) begin
        power_control_reg[pwr_mode_pkg::POWER_ON_FLAG_POS] <= 1'b1;
      end
    end
  end

  // Power-down wake enables.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_enable <= pwr_mode_pkg::WAKE_ENABLE_RESET;
    end else if (wr_wake_enable) begin
      wake_enable <= reg_wdata[5:0];
    end
  end

  // Record which of the six listed sources ended the last interrupt-woken sleep, for software to inspect.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_wake <= '0;
    end else if (mode == pwr_mode_pkg::MODE_PD_STOP && |pd_wake) begin
      last_wake <= pd_wake;
    end else if (mode == pwr_mode_pkg::MODE_IDLE && idle_wake) begin
      last_wake <= irq_pending[pwr_mode_pkg::PD_WAKE_SOURCES-1:0];
    end
  end

  // Service request to the CPU once the clock is back; the CPU then runs
  // the handler and its return lands after the sleeping instruction.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_service <= 1'b0;
    end else begin
      wake_service <= !qualifying_reset && (
        (mode == pwr_mode_pkg::MODE_IDLE && idle_wake) // R4
        || (mode == pwr_mode_pkg::MODE_PD_SETTLE && osc_stable)); // R3
    end
  end

  // A qualifying reset reinitialises the CPU from its reset vector.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_restart <= 1'b0;
    end else begin
      cpu_restart <= qualifying_reset; // R14
    end
  end

  // Clock gating follows the mode flop, so the entering write has already
  // completed when the CPU clock drops on the next edge.
  assign cpu_clk_en = (mode == pwr_mode_pkg::MODE_RUN); // R2 R7 R8
  assign periph_clk_en = (mode == pwr_mode_pkg::MODE_RUN)
    || (mode == pwr_mode_pkg::MODE_IDLE); // R1 R2
  assign cpu_hold = !cpu_clk_en; // R6
  assign port_hold = (mode != pwr_mode_pkg::MODE_RUN); // R6 R12
  assign flash_stop = (mode == pwr_mode_pkg::MODE_PD_STOP); // R12
  assign ram_retain = (mode == pwr_mode_pkg::MODE_PD_STOP)
    || (mode == pwr_mode_pkg::MODE_PD_SETTLE); // R12

  // The oscillator request is combinational from the wake sources so that a
  // pin edge restarts the clock without needing a clock edge to see it.
  assign osc_run = (mode != pwr_mode_pkg::MODE_PD_STOP)
    || (|pd_wake); // R1 R15

  assign serial_rate_double =
    power_control_reg[pwr_mode_pkg::SERIAL_RATE_DOUBLE_POS];
  assign serial_frame_error_select =
    power_control_reg[pwr_mode_pkg::SERIAL_FRAME_ERROR_SELECT_POS];

  // Read multiplexer; narrow registers sit in the low bits.
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (addr_hit(reg_raddr, pwr_mode_pkg::POWER_CONTROL_ADDR)) begin
      reg_rdata[7:0] = power_control_reg;
    end else if (addr_hit(reg_raddr, pwr_mode_pkg::WAKE_ENABLE_ADDR)) begin
      reg_rdata[5:0] = wake_enable;
    end else if (addr_hit(reg_raddr, pwr_mode_pkg::POWER_STATUS_ADDR)) begin
      reg_rdata[1:0] = mode;
      reg_rdata[7:2] = last_wake;
    end
  end
endmodule

// *** tb/pwr_mode_assertions.sv ***
// Concurrent checks on the clock, hold and wake outputs of the controller.
`timescale 1ns/10ps
module pwr_mode_assertions #(
  parameter int IRQ_SOURCES = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Wake and reset causes.
  input wire logic [IRQ_SOURCES-1:0] irq_pending,
  input wire logic reset_power_on,
  input wire logic reset_pin,
  input wire logic reset_brownout,
  input wire logic reset_watchdog,
  input wire logic reset_software,
  input wire logic brownout_detect_enabled,
  input wire logic osc_stable,
  // Controller outputs.
  input wire logic osc_run,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic cpu_hold,
  input wire logic cpu_restart,
  input wire logic wake_service,
  input wire logic flash_stop,
  input wire logic ram_retain,
  input wire logic port_hold
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Software reset is left out on purpose: it must never end a sleep.
  logic qual;
  assign qual = reset_power_on | reset_pin | reset_watchdog |
    (reset_brownout & brownout_detect_enabled);

  a_pd_all_stopped: assert property (
    flash_stop |-> !cpu_clk_en && !periph_clk_en && ram_retain && port_hold)
    else $error("Power-down left a clock or hold wrong.");
  a_idle_periph_on: assert property (
    !cpu_clk_en && !ram_retain |-> periph_clk_en && cpu_hold && port_hold)
    else $error("Idle did not keep peripherals running and CPU frozen.");
  a_idle_irq_wake: assert property (
    periph_clk_en && !cpu_clk_en && (|irq_pending) && !qual
    |=> cpu_clk_en && wake_service)
    else $error("Pending interrupt did not end idle.");
  a_qual_restart: assert property (
    qual |=> cpu_restart && cpu_clk_en && !port_hold)
    else $error("Qualifying reset did not restart the CPU.");
  a_sw_reset_kept: assert property (
    reset_software && !qual && (flash_stop || periph_clk_en) &&
    !cpu_clk_en && !(|irq_pending) |=> !cpu_clk_en)
    else $error("Software reset ended a sleep mode.");
  a_pd_wake_only6: assert property (
    flash_stop && !(|irq_pending[5:0]) |-> !osc_run)
    else $error("Oscillator restarted without a wake source.");
  a_osc_restart: assert property (
    flash_stop && osc_run && !qual |=> ram_retain && !flash_stop)
    else $error("Wake did not move power-down to settling.");
  a_settle_hold: assert property (
    ram_retain && !flash_stop && !osc_stable && !qual
    |=> !cpu_clk_en && !wake_service)
    else $error("Service began before the oscillator was stable.");
  a_settle_done: assert property (
    ram_retain && !flash_stop && osc_stable && !qual
    |=> cpu_clk_en && wake_service)
    else $error("Stable oscillator did not resume the CPU.");
  a_pulse_once: assert property (
    (wake_service || cpu_restart) && !qual |=> !wake_service && !cpu_restart)
    else $error("Restart or service pulse lasted too long.");
endmodule

bind cpu_power_mode_control pwr_mode_assertions #(
  .IRQ_SOURCES(IRQ_SOURCES)
) u_chk (.clk_sys, .rst, .irq_pending, .reset_power_on, .reset_pin,
  .reset_brownout, .reset_watchdog, .reset_software, .brownout_detect_enabled,
  .osc_stable, .osc_run, .cpu_clk_en, .periph_clk_en, .cpu_hold, .cpu_restart,
  .wake_service, .flash_stop, .ram_retain, .port_hold);

// *** tb/osc_model.sv ***
// Oscillator model that reports stability some cycles after it restarts.
`timescale 1ns/10ps
module osc_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Settling time in cycles, zero for a prompt answer.
  input wire logic [3:0] settle,
  // Oscillator control and status.
  input wire logic osc_run,
  output logic osc_stable
);
  logic [3:0] count;
  // Stopping drops stability at the next edge with osc_run low, so a stale flag leaks only into a wake raised in the first stopped cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= 4'h0;
      osc_stable <= 1'b1;
    end else if (!osc_run) begin
      count <= 4'h0;
      osc_stable <= 1'b0;
    end else if (count >= settle) begin
      osc_stable <= 1'b1;
    end else begin
      count <= count + 4'h1;
    end
  end
endmodule

// *** tb/cpu_power_mode_control_bench.sv ***
// Self-checking bench for the power-mode controller and its register bus.
`timescale 1ns/10ps
module cpu_power_mode_control_bench;
  typedef struct {
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0] resp;
  } note_t;
  localparam logic [11:0] PC_A = pwr_mode_pkg::POWER_CONTROL_ADDR;
  localparam logic [11:0] WE_A = pwr_mode_pkg::WAKE_ENABLE_ADDR;
  localparam logic [11:0] ST_A = pwr_mode_pkg::POWER_STATUS_ADDR;
  localparam logic [1:0] OK = pwr_mode_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pwr_mode_pkg::RESP_SLVERR;
  logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, bo_en, osc_stable, osc_run;
  logic cpu_clk_en, periph_clk_en, cpu_hold, cpu_restart, wake_service;
  logic flash_stop, ram_retain, port_hold, srd, sfes;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] irq;
  logic [4:0] rsrc;
  logic [3:0] settle;
  note_t exp_q[$];
  int mismatches, total_checks, ws_cnt, rs_cnt;

  cpu_power_mode_control u_dut (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_pending(irq),
    .reset_power_on(rsrc[0]), .reset_pin(rsrc[1]), .reset_brownout(rsrc[2]),
    .reset_watchdog(rsrc[3]), .reset_software(rsrc[4]),
    .brownout_detect_enabled(bo_en), .osc_stable(osc_stable),
    .osc_run(osc_run), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .cpu_hold(cpu_hold), .cpu_restart(cpu_restart),
    .wake_service(wake_service), .flash_stop(flash_stop),
    .ram_retain(ram_retain), .port_hold(port_hold),
    .serial_rate_double(srd), .serial_frame_error_select(sfes));
  osc_model u_osc (.clk_sys(clk_sys), .rst(rst), .settle(settle),
    .osc_run(osc_run), .osc_stable(osc_stable));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic timeout(input string nm);
    mismatches++;
    $display("Error %s expected answer seen none", nm);
    end_of_test();
  endtask

  // Both write channels are offered together and released as each is taken.
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int n;
    exp_q.push_back('{32'h0, 32'h0, r});
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) timeout("bvalid");
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic bus_rd(input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] m, input logic [1:0] r);
    int n;
    exp_q.push_back('{d, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) timeout("rvalid");
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_ws(input int want);
    int n;
    for (n = 0; n < 60 && ws_cnt < want; n++) @(posedge clk_sys);
    if (n == 60) timeout("wake_service");
  endtask

  // Reset causes are single-cycle pulses.
  task automatic pulse(input logic [4:0] v);
    rsrc <= v;
    @(posedge clk_sys);
    rsrc <= 5'h0;
    @(posedge clk_sys);
  endtask

  // Watcher: counts pulses and takes the oldest note on every bus answer.
  always @(posedge clk_sys) begin
    note_t n;
    if (wake_service === 1'b1) ws_cnt++;
    if (cpu_restart === 1'b1) rs_cnt++;
    if (((bvalid && bready) || (rvalid && rready)) && exp_q.size() > 0) begin
      n = exp_q.pop_front();
      check("resp", {30'h0, n.resp}, {30'h0, rvalid ? rresp : bresp});
      if (rvalid) check("rdata", n.data, rdata & n.mask);
    end
  end

  initial begin
    logic [7:0] v;
    int ws;
    int rs;
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, irq, rsrc, settle} = 73'h0;
    bo_en = 1'b1;
    void'($urandom(81));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus_rd(PC_A, 32'h10, 32'hFF, OK);
    bus_rd(WE_A, 32'h3F, 32'hFF, OK);
    bus_rd(12'h228, 32'h0, 32'hFFFFFFFF, ERR);
    bus_wr(12'h228, 32'hFF, ERR);
    $display("Test registers done");
    // Idle ended by each reset cause, except software and unarmed brown-out.
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom() & 32'hCC) | 8'h21;
      bo_en <= (i != 5);
      bus_wr(PC_A, {24'h0, v}, OK);
      bus_rd(ST_A, 32'h1, 32'h3, OK);
      check("cpu_hold", 32'h1, {31'h0, cpu_hold});
      check("periph_clk_en", 32'h1, {31'h0, periph_clk_en});
      check("serial_rate_double", {31'h0, v[7]}, {31'h0, srd});
      check("frame_error_select", {31'h0, v[6]}, {31'h0, sfes});
      rs = rs_cnt;
      pulse(i == 5 ? 5'h04 : 5'h01 << i);
      if (i < 4) begin
        bus_rd(ST_A, 32'h0, 32'h3, OK);
        bus_rd(PC_A, 32'h0, 32'h3, OK);
        check("restarts", rs + 1, rs_cnt);
      end else begin
        bus_rd(ST_A, 32'h1, 32'h3, OK);
        ws = ws_cnt;
        irq <= 8'h80;
        wait_ws(ws + 1);
        irq <= 8'h00;
        bus_rd(PC_A, {24'h0, v & 8'hDE}, 32'hFF, OK);
      end
    end
    $display("Test idle exits done");
    // Power-down woken by each of the six sources, oscillator prompt or slow.
    for (int s = 0; s < 6; s++) begin
      v = 8'h02 | 8'($urandom() & 32'h1);
      settle <= 4'($urandom_range(9, 0));
      bus_wr(PC_A, {24'h0, v}, OK);
      bus_rd(ST_A, 32'h2, 32'h3, OK);
      check("osc_run", 32'h0, {31'h0, osc_run});
      check("flash_stop", 32'h1, {31'h0, flash_stop});
      check("ram_retain", 32'h1, {31'h0, ram_retain});
      ws = ws_cnt;
      irq <= 8'h01 << s;
      wait_ws(ws + 1);
      irq <= 8'h00;
      bus_rd(ST_A, 32'h4 << s, 32'hFF, OK);
      bus_rd(PC_A, 32'h0, 32'h3, OK);
    end
    $display("Test power-down wakes done");
    // Disabled and unlisted sources are ignored; the pin reset still wakes.
    bus_wr(WE_A, 32'h3E, OK);
    bus_wr(PC_A, 32'h02, OK);
    irq <= 8'hC1;
    bus_rd(ST_A, 32'h2, 32'h3, OK);
    check("osc_run", 32'h0, {31'h0, osc_run});
    rs = rs_cnt;
    pulse(5'h02);
    bus_rd(ST_A, 32'h0, 32'h3, OK);
    check("restarts", rs + 1, rs_cnt);
    irq <= 8'h00;
    bus_wr(WE_A, 32'h3F, OK);
    $display("Test wake filter done");
    end_of_test();
  end
endmodule
